// ==== core/cpu_mode_and_row_guard.v ====
`timescale 1ns/1ns
`include "row_guard_defines.vh"

// What this block does
// RQ1: Every reset starts in hidden boot mode
// RQ2: Hardware picks test mode or system mode
// RQ3: Boot may enter test or system, later contactless; never back
// RQ4: Test mode refused forever after delivery
// RQ5: Boot mode only right after reset
// RQ6: Super-system flag later selects contactless mode, test mode while in test mode
// RQ7: Software cannot change fuses or security options
// RQ8: Top 128 EEPROM bytes form guarded row
// RQ9: 32-byte area readable, never writable by software
// RQ10: 16-byte area software may write-protect
// RQ11: 32-byte write-once area, ones stay set
// RQ12: Disabled card never starts application again
// RQ13: Factory key area lies outside, unprotected
// RQ14: Non-test modes reach one part per memory
// RQ15: Test mode reaches both parts of memories
// RQ16: Partition fixed, set by contactless option only
// RQ17: Virtual addresses translated to physical ones
// RQ18: User mode segments with access and SFR rights
// RQ19: Status word holds super-system and system flags
// RQ20: Direct flag writes can only clear
// RQ21: Forbidden or out-of-range access raises exception
// RQ22: Refused row writes leave content unchanged
module cpu_mode_and_row_guard (
	input  wire                 i_core_clk,
	input  wire                 i_rst,
	input  wire                 i_test_avail,
	input  wire                 i_delivered,
	input  wire                 i_cl_option,
	input  wire                 i_card_dis_option,
	input  wire                 i_flag_wr,
	input  wire [1:0]           i_flag_wdata,
	input  wire                 i_exc_entry,
	input  wire                 i_svec_call,
	input  wire                 i_cvec_call,
	input  wire                 i_user_call,
	input  wire                 i_reti,
	input  wire [1:0]           i_reti_flags,
	input  wire [15:0]          i_cl_sfr_rights,
	input  wire                 i_seg_wr,
	input  wire [`SEG_IW-1:0]   i_seg_idx,
	input  wire [`VA_W-1:0]     i_seg_start,
	input  wire [`VA_W-1:0]     i_seg_end,
	input  wire [`VA_W-1:0]     i_seg_off,
	input  wire [2:0]           i_seg_rights,
	input  wire [15:0]          i_seg_sfr,
	input  wire                 i_acc_valid,
	input  wire                 i_acc_write,
	input  wire                 i_acc_exec,
	input  wire [`VA_W-1:0]     i_acc_vaddr,
	input  wire [7:0]           i_acc_wdata,
	output reg                  o_mem_valid,
	output reg                  o_mem_write,
	output reg  [1:0]           o_mem_sel,
	output reg  [`PA_W-1:0]     o_mem_paddr,
	output reg  [7:0]           o_mem_wdata,
	output reg                  o_row_rvalid,
	output reg  [7:0]           o_row_rdata,
	output reg                  o_exc,
	output reg  [2:0]           o_exc_cause,
	output wire [1:0]           o_mode_status_word,
	output wire [2:0]           o_cpu_mode,
	output reg  [15:0]          o_sfr_rights,
	output wire                 o_card_dead
);

localparam [2:0] MODE_BOOT = 3'h0;
localparam [2:0] MODE_TEST = 3'h1;
localparam [2:0] MODE_CL   = 3'h2;
localparam [2:0] MODE_SYS  = 3'h3;
localparam [2:0] MODE_USER = 3'h4;
localparam [2:0] MODE_DEAD = 3'h5;

reg  [3:0]        s1;
reg  [3:0]        s2;
reg  [3:0]        s3;
reg  [3:0]        pin_f;
reg  [2:0]        mode;
reg  [2:0]        next_mode;
reg  [2:0]        boot_cnt;
reg               cl_cfg;
reg               card_opt;
reg  [7:0]        row [0:127];
wire              super_system_flag;
wire              system_level_flag;
wire              boot_end;
wire              test_ok;
wire              card_off;
wire              seg_ok;
wire [`VA_W-1:0]  seg_va;
wire [15:0]       seg_sfr;
wire [`VA_W-1:0]  va_eff;
wire [1:0]        region;
wire [`PA_W-1:0]  off;
wire [6:0]        roff;
wire [15:0]       lock;
reg  [`PA_W-1:0]  base;
reg  [`PA_W-1:0]  limit;
reg  [2:0]        cause;
integer           n;

// ----------------------------------------
// Decoding helpers
// ----------------------------------------
function [2:0] flags_mode;
	input [1:0] f;
	input [2:0] cur;
	begin
		if (f[1])
			flags_mode = (cur == MODE_TEST) ? MODE_TEST : MODE_CL; // see RQ6
		else if (f[0])
			flags_mode = MODE_SYS;
		else
			flags_mode = MODE_USER; // see RQ19
	end
endfunction

function [`PA_W-1:0] mem_size;
	input [1:0] r;
	begin
		if (r == `REGION_ROM)
			mem_size = `ROM_SIZE;
		else if (r == `REGION_EE)
			mem_size = `EE_SIZE;
		else if (r == `REGION_RAM)
			mem_size = `RAM_SIZE;
		else
			mem_size = `ROW_BYTES;
	end
endfunction

function [`PA_W-1:0] cl_size;
	input [1:0] r;
	input       cl;
	begin
		if (!cl)
			cl_size = {`PA_W{1'b0}};
		else if (r == `REGION_ROM)
			cl_size = `ROM_CL_SIZE;
		else if (r == `REGION_EE)
			cl_size = `EE_CL_SIZE;
		else if (r == `REGION_RAM)
			cl_size = `RAM_CL_SIZE;
		else
			cl_size = {`PA_W{1'b0}};
	end
endfunction

// New row byte for a write; refused parts keep the old value
function [7:0] row_merge;
	input [6:0] a;
	input [7:0] old;
	input [7:0] wd;
	input       lk;
	input       tm;
	begin
		if (tm)
			row_merge = wd;
		else if (a < `ROW_CARD)
			row_merge = old; // see RQ7
		else if (a < `ROW_RO_LO)
			row_merge = old | wd;
		else if (a < `ROW_WP_LO)
			row_merge = old; // see RQ9
		else if (a < `ROW_WO_LO)
			row_merge = lk ? old : wd; // see RQ10
		else
			row_merge = old | wd; // see RQ11
	end
endfunction

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
// Bits: 0 test avail, 1 delivered, 2 contactless, 3 card disable
localparam [3:0] PIN_INIT = `PIN_RST;
genvar g;
generate
	for (g = 0; g < 4; g = g + 1) begin : pin_sync
		always @(posedge i_core_clk) begin
			// Chain runs through reset so pins are settled at boot end
			s1[g] <= (g == 0) ? i_test_avail :
			         (g == 1) ? i_delivered :
			         (g == 2) ? i_cl_option : i_card_dis_option;
			s2[g] <= s1[g];
			s3[g] <= s2[g];
			if (i_rst)
				pin_f[g] <= PIN_INIT[g];
			else if (s2[g] == s3[g])
				pin_f[g] <= s3[g];
		end
	end
endgenerate

// ----------------------------------------
// Mode sequencing
// ----------------------------------------
assign boot_end = (mode == MODE_BOOT) && (boot_cnt == `BOOT_CYC - 3'h1);
assign test_ok  = pin_f[0] && !pin_f[1]; // see RQ4
assign card_off = pin_f[3] && row[`ROW_CARD][`ROW_CARD_BIT];
assign super_system_flag = (mode == MODE_BOOT) || (mode == MODE_TEST) ||
                           (mode == MODE_CL);
assign system_level_flag = (mode == MODE_SYS);
assign o_mode_status_word = {super_system_flag, system_level_flag}; // see RQ19
assign o_cpu_mode  = mode;
assign o_card_dead = (mode == MODE_DEAD);

always @* begin
	next_mode = mode;
	case (mode)
	MODE_BOOT: begin
		if (boot_end) begin
			if (test_ok)
				next_mode = MODE_TEST; // see RQ2
			else if (card_off)
				next_mode = MODE_DEAD; // see RQ12
			else
				next_mode = MODE_SYS; // see RQ2
		end
	end
	MODE_DEAD: begin
		next_mode = MODE_DEAD;
	end
	default: begin
		// Nothing here returns to boot; only reset does
		if (i_exc_entry || i_svec_call) begin
			if (mode == MODE_USER)
				next_mode = MODE_SYS;
		end else if (i_reti) begin
			next_mode = flags_mode(i_reti_flags, mode); // see RQ5
		end else if (i_cvec_call && cl_cfg) begin
			next_mode = MODE_CL; // see RQ3
		end else if (i_user_call && mode == MODE_SYS) begin
			next_mode = MODE_USER;
		end else if (i_flag_wr) begin
			next_mode = flags_mode(o_mode_status_word & i_flag_wdata,
			                       mode); // see RQ20
		end
	end
	endcase
end

always @(posedge i_core_clk) begin
	if (i_rst) begin
		mode     <= MODE_BOOT; // see RQ1
		boot_cnt <= 3'h0;
		cl_cfg   <= 1'b0;
		card_opt <= 1'b0;
	end else begin
		mode <= next_mode;
		if (mode == MODE_BOOT && !boot_end)
			boot_cnt <= boot_cnt + 3'h1;
		// Options captured once; no run-time path changes them
		if (boot_end) begin
			cl_cfg   <= pin_f[2]; // see RQ16
			card_opt <= pin_f[3]; // see RQ7
		end
	end
end

// ----------------------------------------
// Address translation and partition
// ----------------------------------------
segment_table u_seg (
	.i_core_clk (i_core_clk),
	.i_rst      (i_rst),
	.i_wr       (i_seg_wr && mode == MODE_SYS),
	.i_idx      (i_seg_idx),
	.i_start    (i_seg_start),
	.i_end      (i_seg_end),
	.i_off      (i_seg_off),
	.i_rights   (i_seg_rights),
	.i_sfr      (i_seg_sfr),
	.i_va       (i_acc_vaddr),
	.i_write    (i_acc_write),
	.i_exec     (i_acc_exec),
	.o_ok       (seg_ok),
	.o_va       (seg_va),
	.o_sfr      (seg_sfr)
);

assign va_eff = (mode == MODE_USER) ? seg_va : i_acc_vaddr; // see RQ18
assign region = va_eff[`VA_W-1:`PA_W];
assign off    = va_eff[`PA_W-1:0];
assign roff   = off[6:0];
assign lock   = {row[`ROW_LOCK_HI], row[`ROW_LOCK_LO]};

// Contactless part sits at the bottom, the other part above it
always @* begin
	if (mode == MODE_TEST) begin
		base  = {`PA_W{1'b0}};
		limit = mem_size(region); // see RQ15
	end else if (mode == MODE_CL) begin
		base  = {`PA_W{1'b0}};
		limit = cl_size(region, cl_cfg); // see RQ14
	end else begin
		base  = cl_size(region, cl_cfg);
		limit = mem_size(region) - cl_size(region, cl_cfg); // see RQ14
		// Row space is cut from what software may store
		if (region == `REGION_EE)
			limit = limit - `ROW_BYTES; // see RQ8
	end
end

always @* begin
	cause = 3'h0;
	if (i_svec_call && mode != MODE_USER && mode != MODE_BOOT)
		cause = `EXC_SVEC;
	else if (i_acc_valid && mode == MODE_USER && !seg_ok)
		cause = `EXC_USER; // see RQ21
	else if (i_acc_valid && off >= limit)
		cause = `EXC_RANGE; // see RQ21
end

// ----------------------------------------
// Access pipeline and protected row
// ----------------------------------------
always @(posedge i_core_clk) begin
	if (i_rst) begin
		o_mem_valid  <= 1'b0;
		o_mem_write  <= 1'b0;
		o_mem_sel    <= 2'h0;
		o_mem_paddr  <= {`PA_W{1'b0}};
		o_mem_wdata  <= 8'h00;
		o_row_rvalid <= 1'b0;
		o_row_rdata  <= 8'h00;
		o_exc        <= 1'b0;
		o_exc_cause  <= 3'h0;
	end else begin
		o_mem_valid  <= 1'b0;
		o_row_rvalid <= 1'b0;
		o_exc        <= cause != 3'h0;
		o_exc_cause  <= cause;
		if (i_acc_valid && cause == 3'h0 && mode != MODE_DEAD) begin
			if (region == `REGION_ROW) begin
				// Row never reaches the EEPROM port; served here
				o_row_rvalid <= !i_acc_write;
				if (mode != MODE_TEST && roff < `ROW_CARD)
					o_row_rdata <= 8'h00; // see RQ7
				else
					o_row_rdata <= row[roff]; // see RQ8
			end else begin
				o_mem_valid <= 1'b1;
				o_mem_write <= i_acc_write;
				o_mem_sel   <= region;
				o_mem_paddr <= base + off; // see RQ17
				o_mem_wdata <= i_acc_wdata;
			end
		end
	end
end

// Row acts as non-volatile storage; reset leaves it alone
initial begin
	for (n = 0; n < 128; n = n + 1)
		row[n] = 8'h00;
end

always @(posedge i_core_clk) begin
	if (!i_rst && i_acc_valid && i_acc_write && cause == 3'h0 &&
	    mode != MODE_DEAD && region == `REGION_ROW)
		row[roff] <= row_merge(roff, row[roff], i_acc_wdata,
		                       lock[roff[3:0]], mode == MODE_TEST); // see RQ22
end

// ----------------------------------------
// Peripheral rights per mode
// ----------------------------------------
always @(posedge i_core_clk) begin
	if (i_rst) begin
		o_sfr_rights <= 16'hffff;
	end else if (mode == MODE_USER) begin
		if (i_acc_valid && i_acc_exec && seg_ok)
			o_sfr_rights <= seg_sfr; // see RQ18
	end else if (mode == MODE_CL) begin
		o_sfr_rights <= i_cl_sfr_rights;
	end else begin
		o_sfr_rights <= 16'hffff;
	end
end

// The factory key area is plain EEPROM outside the row, no guard here; see RQ13

endmodule

// ==== core/row_guard_defines.vh ====
`ifndef ROW_GUARD_DEFINES_VH
`define ROW_GUARD_DEFINES_VH

// ----------------------------------------
// Address widths and memory map
// ----------------------------------------
`define VA_W        24
`define PA_W        22
`define REGION_ROM  2'h0
`define REGION_EE   2'h1
`define REGION_RAM  2'h2
`define REGION_ROW  2'h3

// ----------------------------------------
// Implemented sizes and contactless parts
// ----------------------------------------
`define ROM_SIZE    22'h040000
`define EE_SIZE     22'h010000
`define RAM_SIZE    22'h002000
`define ROM_CL_SIZE 22'h008000
`define EE_CL_SIZE  22'h001000
`define RAM_CL_SIZE 22'h000200

// ----------------------------------------
// Protected row layout, byte offsets
// ----------------------------------------
`define ROW_BYTES   22'h000080
`define ROW_CARD    7'h2d
`define ROW_LOCK_LO 7'h2e
`define ROW_LOCK_HI 7'h2f
`define ROW_RO_LO   7'h30
`define ROW_WP_LO   7'h50
`define ROW_WO_LO   7'h60
`define ROW_CARD_BIT 0

// ----------------------------------------
// Timing, causes, segments
// ----------------------------------------
`define BOOT_CYC    3'h4
`define EXC_USER    3'h1
`define EXC_RANGE   3'h2
`define EXC_SVEC    3'h3
`define SEG_N       4
`define SEG_IW      2
`define PIN_RST     4'h2

`endif

// ==== core/segment_table.v ====
`timescale 1ns/1ns
`include "row_guard_defines.vh"

module segment_table (
	input  wire                 i_core_clk,
	input  wire                 i_rst,
	input  wire                 i_wr,
	input  wire [`SEG_IW-1:0]   i_idx,
	input  wire [`VA_W-1:0]     i_start,
	input  wire [`VA_W-1:0]     i_end,
	input  wire [`VA_W-1:0]     i_off,
	input  wire [2:0]           i_rights,
	input  wire [15:0]          i_sfr,
	input  wire [`VA_W-1:0]     i_va,
	input  wire                 i_write,
	input  wire                 i_exec,
	output reg                  o_ok,
	output reg  [`VA_W-1:0]     o_va,
	output reg  [15:0]          o_sfr
);

reg  [`VA_W-1:0]  seg_start  [0:`SEG_N-1];
reg  [`VA_W-1:0]  seg_end    [0:`SEG_N-1];
reg  [`VA_W-1:0]  seg_off    [0:`SEG_N-1];
reg  [2:0]        seg_rights [0:`SEG_N-1];
reg  [15:0]       seg_sfr    [0:`SEG_N-1];
wire [2:0]        need;
integer           k;

// ----------------------------------------
// Table storage, written from system mode
// ----------------------------------------
genvar g;
generate
	for (g = 0; g < `SEG_N; g = g + 1) begin : seg_reg
		always @(posedge i_core_clk) begin
			if (i_rst) begin
				seg_start[g]  <= {`VA_W{1'b0}};
				seg_end[g]    <= {`VA_W{1'b0}};
				seg_off[g]    <= {`VA_W{1'b0}};
				seg_rights[g] <= 3'h0;
				seg_sfr[g]    <= 16'h0000;
			end else if (i_wr && i_idx == g) begin
				seg_start[g]  <= i_start;
				seg_end[g]    <= i_end;
				seg_off[g]    <= i_off;
				seg_rights[g] <= i_rights;
				seg_sfr[g]    <= i_sfr;
			end
		end
	end
endgenerate

// Rights bits: 0 read, 1 write, 2 execute
assign need = i_exec ? 3'h4 : (i_write ? 3'h2 : 3'h1);

// ----------------------------------------
// Lookup, lowest index wins
// ----------------------------------------
always @* begin
	o_ok  = 1'b0;
	o_va  = i_va;
	o_sfr = 16'h0000;
	for (k = `SEG_N - 1; k >= 0; k = k - 1) begin
		if (i_va >= seg_start[k] && i_va <= seg_end[k]) begin
			o_ok  = (seg_rights[k] & need) != 3'h0; // see RQ18
			o_va  = i_va + seg_off[k];
			o_sfr = seg_sfr[k];
		end
	end
end

endmodule

// ==== verification/cpu_core_model.sv ====
`timescale 1ns/1ns

// ----------------------------------------
// CPU side issuing byte accesses
// ----------------------------------------
module cpu_core_model (
	input  wire         i_core_clk,
	output reg          o_acc_valid,
	output reg          o_acc_write,
	output reg          o_acc_exec,
	output reg  [23:0]  o_acc_vaddr,
	output reg  [7:0]   o_acc_wdata
);
	initial begin
		o_acc_valid = 1'b0;
		o_acc_write = 1'b0;
		o_acc_exec = 1'b0;
		o_acc_vaddr = 24'h000000;
		o_acc_wdata = 8'h00;
	end

	// Gap gives prompt or slow issue; released bus shows inverted value
	task access(input [1:0] kind, input [23:0] va, input [7:0] wd, input integer gap);
		repeat (gap) @(negedge i_core_clk);
		@(negedge i_core_clk);
		o_acc_valid = 1'b1;
		o_acc_write = kind[0];
		o_acc_exec = kind[1];
		o_acc_vaddr = va;
		o_acc_wdata = wd;
		@(negedge i_core_clk);
		o_acc_valid = 1'b0;
		o_acc_write = 1'b0;
		o_acc_exec = 1'b0;
		o_acc_vaddr = ~va;
		o_acc_wdata = ~wd;
	endtask
endmodule

// ==== verification/cpu_mode_and_row_guard_test.sv ====
`timescale 1ns/1ns
`include "row_guard_defines.vh"

module cpu_mode_and_row_guard_test;
	reg                i_core_clk, i_rst, i_test_avail, i_delivered, i_card_dis_option;
	reg                i_flag_wr, i_exc_entry, i_svec_call, i_cvec_call, i_user_call, i_reti;
	reg  [1:0]         i_flag_wdata, i_reti_flags;
	reg  [15:0]        i_cl_sfr_rights, i_seg_sfr;
	reg                i_seg_wr, i_cl_option;
	reg  [1:0]         i_seg_idx;
	reg  [2:0]         i_seg_rights;
	reg  [`VA_W-1:0]   i_seg_start, i_seg_end, i_seg_off;
	wire               i_acc_valid, i_acc_write, i_acc_exec;
	wire [`VA_W-1:0]   i_acc_vaddr;
	wire [7:0]         i_acc_wdata, o_mem_wdata, o_row_rdata;
	wire               o_mem_valid, o_mem_write, o_row_rvalid, o_exc, o_card_dead;
	wire [1:0]         o_mem_sel, o_mode_status_word;
	wire [`PA_W-1:0]   o_mem_paddr;
	wire [2:0]         o_exc_cause, o_cpu_mode;
	wire [15:0]        o_sfr_rights;
	integer            err_count = 0, n_compared = 0, cyc = 0, i, off;
	integer            row_m [0:127];
	reg  [7:0]         d;

	cpu_mode_and_row_guard uut (.i_core_clk, .i_rst, .i_test_avail, .i_delivered,
		.i_cl_option, .i_card_dis_option, .i_flag_wr, .i_flag_wdata, .i_exc_entry,
		.i_svec_call, .i_cvec_call, .i_user_call, .i_reti, .i_reti_flags, .i_cl_sfr_rights,
		.i_seg_wr, .i_seg_idx, .i_seg_start, .i_seg_end, .i_seg_off, .i_seg_rights, .i_seg_sfr,
		.i_acc_valid, .i_acc_write, .i_acc_exec, .i_acc_vaddr, .i_acc_wdata, .o_mem_valid,
		.o_mem_write, .o_mem_sel, .o_mem_paddr, .o_mem_wdata, .o_row_rvalid, .o_row_rdata,
		.o_exc, .o_exc_cause, .o_mode_status_word, .o_cpu_mode, .o_sfr_rights, .o_card_dead);
	cpu_core_model cpu (.i_core_clk, .o_acc_valid(i_acc_valid), .o_acc_write(i_acc_write),
		.o_acc_exec(i_acc_exec), .o_acc_vaddr(i_acc_vaddr), .o_acc_wdata(i_acc_wdata));

	initial begin
		i_core_clk = 1'b0;
		forever #25 i_core_clk = ~i_core_clk;
	end
	always @(posedge i_core_clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			err_count = err_count + 1;
			stop_test;
		end
	end

	// ----------------------------------------
	// Checking and stimulus helpers
	// ----------------------------------------
	task stop_test;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input string n, input [31:0] e, input [31:0] g);
		n_compared = n_compared + 1;
		if (g !== e) begin
			err_count = err_count + 1;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// Event order: exception, svec, cvec, user call, return, flag write
	task ev(input integer k, input [1:0] f);
		@(negedge i_core_clk);
		{i_exc_entry, i_svec_call, i_cvec_call, i_user_call, i_reti, i_flag_wr} = 6'h20 >> k;
		i_flag_wdata = f;
		i_reti_flags = f;
		@(negedge i_core_clk);
		{i_exc_entry, i_svec_call, i_cvec_call, i_user_call, i_reti, i_flag_wr} = 6'h00;
	endtask
	task do_reset(input ta, input dl, input cd);
		@(negedge i_core_clk);
		i_rst = 1'b1;
		i_test_avail = ta;
		i_delivered = dl;
		i_card_dis_option = cd;
		repeat (8) @(negedge i_core_clk);
		chk("boot mode", 3'h0, o_cpu_mode);
		chk("boot word", 2'b10, o_mode_status_word);
		i_rst = 1'b0;
		repeat (6) @(negedge i_core_clk);
	endtask
	task rd(input [23:0] va);
		cpu.access(2'b00, va, 8'h00, $urandom % 2);
	endtask
	task rrow(input integer o, input tm);
		rd(24'hc00000 + o);
		chk("row valid", 1'b1, o_row_rvalid);
		chk("row data", (tm || o >= 'h2d) ? row_m[o] : 0, o_row_rdata);
	endtask
	// Reference row: write-once areas OR in, locked bytes keep content
	task wrow(input integer o, input [7:0] v, input tm);
		cpu.access(2'b01, 24'hc00000 + o, v, 0);
		if (tm)
			row_m[o] = v;
		else if (o == 'h2d || o == 'h2e || o == 'h2f || o >= 'h60)
			row_m[o] = row_m[o] | v;
		else if (o >= 'h50 && o < 'h60 && !(((row_m['h2f] << 8) | row_m['h2e]) >> (o - 'h50) & 1))
			row_m[o] = v;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		d = $urandom(45126);
		{i_flag_wr, i_exc_entry, i_svec_call, i_cvec_call, i_user_call, i_reti} = 6'h00;
		{i_flag_wdata, i_reti_flags, i_seg_wr, i_seg_idx, i_seg_rights, i_cl_option} = 11'h000;
		{i_seg_start, i_seg_end, i_seg_off} = 72'h0;
		i_cl_sfr_rights = $urandom;
		i_seg_sfr = 16'h0000;
		do_reset(1'b1, 1'b0, 1'b0);
		chk("test mode", 3'h1, o_cpu_mode);
		rd(`ROM_SIZE - 1);
		chk("test rom paddr", `ROM_SIZE - 1, o_mem_paddr);
		for (i = 0; i < 128; i = i + 1) begin
			d = (i >= 'h2d && i <= 'h2f) ? 8'h00 : $urandom;
			wrow(i, d, 1'b1);
		end
		rrow(5, 1'b1);
		do_reset(1'b1, 1'b1, 1'b0);
		chk("system mode", 3'h3, o_cpu_mode);
		chk("system word", 2'b01, o_mode_status_word);
		chk("sfr rights", 16'hffff, o_sfr_rights);
		for (i = 0; i < 128; i = i + 9)
			rrow(i, 1'b0);
		for (i = 0; i < 60; i = i + 1) begin
			off = $urandom % 128;
			wrow(off, $urandom, 1'b0);
			rrow(off, 1'b0);
		end
		rd(24'h400000 + `EE_SIZE - `ROW_BYTES - 1);
		chk("ee paddr", `EE_SIZE - `ROW_BYTES - 1, o_mem_paddr);
		rd(24'h400000 + `EE_SIZE - `ROW_BYTES);
		chk("ee row hidden", 1'b0, o_mem_valid);
		rd(`ROM_SIZE);
		chk("range cause", `EXC_RANGE, o_exc ? o_exc_cause : 3'h0);
		cpu.access(2'b01, 24'h800010, 8'h5a, 0);
		chk("ram wr", {1'b1, 2'h2, 8'h5a}, {o_mem_write, o_mem_sel, o_mem_wdata});
		ev(3, 2'b00);
		chk("user word", 2'b00, o_mode_status_word);
		ev(5, 2'b11);
		chk("flag set refused", 2'b00, o_mode_status_word);
		ev(1, 2'b00);
		chk("svec to system", 3'h3, o_cpu_mode);
		ev(2, 2'b00);
		chk("cvec no option", 3'h3, o_cpu_mode);
		ev(4, 2'b00);
		chk("return to user", 3'h4, o_cpu_mode);
		ev(0, 2'b00);
		ev(5, 2'b10);
		chk("flag clear", 3'h4, o_cpu_mode);
		ev(0, 2'b00);
		@(negedge i_core_clk);
		{i_seg_wr, i_seg_idx, i_seg_rights} = 6'h25;
		{i_seg_start, i_seg_end, i_seg_off} = {24'h400000, 24'h40ffff, 24'h000000};
		i_seg_sfr = $urandom;
		@(negedge i_core_clk);
		i_seg_wr = 1'b0;
		ev(3, 2'b00);
		rd(24'h400020);
		chk("segment paddr", 22'h000020, o_mem_valid ? o_mem_paddr : 22'h3fffff);
		cpu.access(2'b10, 24'h400020, 8'h00, 0);
		chk("segment sfr", i_seg_sfr, o_sfr_rights);
		cpu.access(2'b01, 24'h400020, 8'h00, 0);
		chk("no write cause", `EXC_USER, o_exc ? o_exc_cause : 3'h0);
		ev(1, 2'b00);
		wrow('h2d, 8'h01, 1'b0);
		// Contactless option: partition moves, vector call reaches contactless mode
		i_cl_option = 1'b1;
		do_reset(1'b0, 1'b1, 1'b0);
		ev(2, 2'b00);
		chk("cvec to contactless", 3'h2, o_cpu_mode);
		rd(24'h400000 + `EE_CL_SIZE - 1);
		chk("cl paddr", `EE_CL_SIZE - 1, o_mem_paddr);
		rd(24'h400000 + `EE_CL_SIZE);
		chk("cl range", `EXC_RANGE, o_exc ? o_exc_cause : 3'h0);
		ev(4, 2'b01);
		rd(24'h400000);
		chk("sys part paddr", `EE_CL_SIZE, o_mem_valid ? o_mem_paddr : 22'h3fffff);
		rd(24'h400000 + `EE_SIZE - `EE_CL_SIZE - `ROW_BYTES);
		chk("sys part end", `EXC_RANGE, o_exc ? o_exc_cause : 3'h0);
		do_reset(1'b0, 1'b1, 1'b1);
		chk("card dead", 1'b1, o_card_dead);
		rd(24'h400010);
		chk("dead no answer", 1'b0, o_mem_valid);
		stop_test;
	end
endmodule

// ==== verification/mode_guard_props.sv ====
`timescale 1ns/1ns
`include "row_guard_defines.vh"

// ----------------------------------------
// Mode sequencing and access checks
// ----------------------------------------
module mode_guard_props (
	input wire              i_core_clk,
	input wire              i_rst,
	input wire              i_delivered,
	input wire              i_cl_option,
	input wire              i_flag_wr,
	input wire              i_exc_entry,
	input wire              i_svec_call,
	input wire              i_cvec_call,
	input wire              i_user_call,
	input wire              i_reti,
	input wire              i_acc_valid,
	input wire              i_acc_write,
	input wire [`VA_W-1:0]  i_acc_vaddr,
	input wire              o_mem_valid,
	input wire [1:0]        o_mem_sel,
	input wire [`PA_W-1:0]  o_mem_paddr,
	input wire              o_row_rvalid,
	input wire              o_exc,
	input wire [2:0]        o_exc_cause,
	input wire [1:0]        o_mode_status_word,
	input wire [2:0]        o_cpu_mode,
	input wire              o_card_dead
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	wire other_ev = i_exc_entry | i_svec_call | i_cvec_call | i_reti;
	wire live = o_cpu_mode != 3'h0 && o_cpu_mode != 3'h5;
	wire sys_rd = i_acc_valid && !i_acc_write && o_cpu_mode == 3'h3 && !i_cl_option;
	wire ee_hit = i_acc_vaddr[23:22] == 2'h1;

	boot_hold_a: assert property ($fell(i_rst) |->
		(o_cpu_mode == 3'h0)[*4] ##1 o_cpu_mode != 3'h0) else $error("boot phase length wrong");
	no_reboot_a: assert property (o_cpu_mode != 3'h0 |=> o_cpu_mode != 3'h0)
		else $error("boot mode came back");
	test_entry_a: assert property (o_cpu_mode inside {3'h2, 3'h3, 3'h4, 3'h5}
		|=> o_cpu_mode != 3'h1) else $error("test mode entered outside boot");
	test_lock_a: assert property (o_cpu_mode == 3'h0 && i_delivered && $past(i_delivered, 4)
		|=> o_cpu_mode != 3'h1) else $error("test mode after delivery");
	user_word_a: assert property (live |->
		((o_cpu_mode == 3'h4) == (o_mode_status_word == 2'b00))) else $error("status word mismatch");
	flag_clear_a: assert property (i_flag_wr && !other_ev && !i_user_call |=>
		(o_mode_status_word & ~$past(o_mode_status_word)) == 2'b00) else $error("flag write set bit");
	read_answer_a: assert property (i_acc_valid && !i_acc_write && live |=>
		$onehot({o_mem_valid, o_row_rvalid, o_exc})) else $error("read not answered once");
	rom_range_a: assert property (sys_rd && i_acc_vaddr[23:22] == 2'h0
		&& i_acc_vaddr[21:0] >= `ROM_SIZE |=> o_exc && o_exc_cause == `EXC_RANGE)
		else $error("range exception missing");
	ee_xlate_a: assert property (sys_rd && ee_hit && i_acc_vaddr[21:0] < `EE_SIZE - `ROW_BYTES
		|=> o_mem_valid && o_mem_sel == 2'h1 && o_mem_paddr == $past(i_acc_vaddr[21:0]))
		else $error("eeprom translation wrong");
	row_hidden_a: assert property (sys_rd && ee_hit && i_acc_vaddr[21:0] >= `EE_SIZE - `ROW_BYTES
		&& i_acc_vaddr[21:0] < `EE_SIZE |=> !o_mem_valid) else $error("row reached as storage");
	dead_quiet_a: assert property (o_card_dead |=> !o_mem_valid && !o_row_rvalid)
		else $error("dead card answered");

	user_seen_c: cover property (o_cpu_mode == 3'h3 ##1 o_cpu_mode == 3'h4);
	row_read_c: cover property (o_row_rvalid);
	range_exc_c: cover property (o_exc && o_exc_cause == `EXC_RANGE);
endmodule

bind cpu_mode_and_row_guard mode_guard_props chk_i (.i_core_clk, .i_rst, .i_delivered,
	.i_cl_option, .i_flag_wr, .i_exc_entry, .i_svec_call, .i_cvec_call, .i_user_call,
	.i_reti, .i_acc_valid, .i_acc_write, .i_acc_vaddr, .o_mem_valid, .o_mem_sel,
	.o_mem_paddr, .o_row_rvalid, .o_exc, .o_exc_cause, .o_mode_status_word, .o_cpu_mode,
	.o_card_dead);
